// >>> include/adcrs_map.svh
`ifndef ADCRS_MAP_SVH
`define ADCRS_MAP_SVH
// register byte offsets
`define ADCRS_CTRL_OFF 12'h000
`define ADCRS_MODE_OFF 12'h004
`define ADCRS_CHEN_OFF 12'h010
`define ADCRS_CHDIS_OFF 12'h014
`define ADCRS_STAT_OFF 12'h01C
`define ADCRS_LAST_OFF 12'h020
`define ADCRS_IMASK_OFF 12'h024
`define ADCRS_ISTAT_OFF 12'h028
`define ADCRS_CHRES_OFF 12'h030
// field positions
`define ADCRS_CTRL_START 1
`define ADCRS_MODE_SLEEP 5
`define ADCRS_STAT_OVR_LSB 8
`define ADCRS_STAT_DATA_READY_FLAG 16
`define ADCRS_STAT_GOVR 17
`define ADCRS_LAST_CH_LSB 12
// interrupt event bits
`define ADCRS_IRQ_DATA_READY_FLAG 0
`define ADCRS_IRQ_GOVR 1
`define ADCRS_IRQ_OVR 2
// reset values
`define ADCRS_MODE_RST 32'h0000_0000
`define ADCRS_MASK_RST 3'h0
`endif

// >>> include/adcrs_pkg.sv
package adcrs_pkg;
	localparam int ADCRS_NCH = 8;
	localparam int ADCRS_RW = 10;
	typedef logic [ADCRS_NCH-1:0] adcrs_chmask_t;
	typedef logic [ADCRS_RW-1:0] adcrs_result_t;
	typedef logic [2:0] adcrs_chidx_t;
	typedef enum logic [2:0] {
		ADCRS_AWAKE = 3'b001,
		ADCRS_ARMED = 3'b010,
		ADCRS_ASLEEP = 3'b100
	} adcrs_sleep_t;
endpackage

// >>> rtl/adcrs_top.sv
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "adcrs_map.svh"
// Notes on behaviour
// - only a read of the last-result register clears data ready; channel reads do not.
// - end of conversion on an enabled channel stores both results and sets data ready, even with a disable in the same cycle.
// - a channel read coinciding with an end of conversion elsewhere still sets data ready.
// - data ready is set only when data is stored; a coinciding last read with a disabled-channel end leaves it clear.
// - a store while data ready is still set raises the global overrun flag.
// - a status read clears global overrun, unless a new overrun happens in the same cycle.
// - a channel read coinciding with an overrun-causing store still sets global overrun.
// - a disable coinciding with an overrun-causing store still sets global overrun.
// - an end of conversion on an enabled channel whose done flag is set raises that channel's overrun flag.
// - a status read clears every channel overrun flag not newly set in the same cycle, even with a coinciding end of conversion after done was cleared.
// - reading a channel register, or the last register holding that channel, clears its done flag.
// - a channel read clears only that channel's done flag.
// - a disabled channel never gets its done flag raised.
// - sleep chosen while idle takes effect only after a following conversion completes.
module adcrs_top (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic conv_done,
	input wire adcrs_pkg::adcrs_chidx_t conv_ch,
	input wire adcrs_pkg::adcrs_result_t conv_data,
	input wire logic conv_busy,
	output logic conv_start,
	output logic sleep_now,
	output adcrs_pkg::adcrs_chmask_t ch_enable,
	output logic irq
);
	import adcrs_pkg::*;

	adcrs_result_t chan_res [ADCRS_NCH];
	adcrs_result_t last_res;
	adcrs_chidx_t last_ch;
	adcrs_chmask_t done_flag;
	adcrs_chmask_t channel_overrun_flag;
	logic data_ready_flag;
	logic global_overrun_flag;
	logic [31:0] mode_reg;
	logic [2:0] irq_mask;
	logic [2:0] irq_stat;
	adcrs_sleep_t slp;
	adcrs_sleep_t next_slp;

	////////////////////////////////////////////////////////////////////////
	// bus decode
	logic acc, wr_acc, rd_acc;
	logic rd_stat, rd_last;
	adcrs_chidx_t rd_idx;
	assign acc = psel && penable;
	assign wr_acc = acc && pwrite;
	assign rd_acc = acc && !pwrite;
	assign pready = 1'b1;
	assign rd_stat = rd_acc && paddr == `ADCRS_STAT_OFF;
	assign rd_last = rd_acc && paddr == `ADCRS_LAST_OFF;
	// channel registers occupy 0x030..0x04C, one word each
	logic chan_hit;
	assign chan_hit = rd_acc && paddr >= `ADCRS_CHRES_OFF && paddr < `ADCRS_CHRES_OFF + 12'h020
		&& paddr[1:0] == 2'b00;
	assign rd_idx = 3'((paddr - `ADCRS_CHRES_OFF) >> 2);

	// unmapped words answer with an error and change nothing
	logic mapped;
	always_comb begin
		mapped = paddr[1:0] == 2'b00 && (paddr == `ADCRS_CTRL_OFF || paddr == `ADCRS_MODE_OFF
			|| paddr == `ADCRS_CHEN_OFF || paddr == `ADCRS_CHDIS_OFF
			|| paddr == `ADCRS_STAT_OFF || paddr == `ADCRS_LAST_OFF
			|| paddr == `ADCRS_IMASK_OFF || paddr == `ADCRS_ISTAT_OFF
			|| (paddr >= `ADCRS_CHRES_OFF && paddr < `ADCRS_CHRES_OFF + 12'h020));
	end
	assign pslverr = acc && !mapped;

	////////////////////////////////////////////////////////////////////////
	// conversion event qualification
	logic store;
	logic ch_disable_now;
	assign store = conv_done && ch_enable[conv_ch];
	assign ch_disable_now = wr_acc && paddr == `ADCRS_CHDIS_OFF;

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			ch_enable <= '0;
		else if (wr_acc && paddr == `ADCRS_CHEN_OFF)
			ch_enable <= ch_enable | pwdata[ADCRS_NCH-1:0];
		else if (ch_disable_now)
			ch_enable <= ch_enable & ~pwdata[ADCRS_NCH-1:0];
	end

	// results: disables do not block a store on a still-enabled channel
	// an end on a disabled channel leaves both result registers untouched
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			last_res <= '0;
			last_ch <= '0;
			for (int i = 0; i < ADCRS_NCH; i++)
				chan_res[i] <= '0;
		end else if (store) begin
			chan_res[conv_ch] <= conv_data;
			last_res <= conv_data;
			last_ch <= conv_ch;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-channel done and overrun flags; set wins over clear
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			done_flag <= '0;
			channel_overrun_flag <= '0;
		end else begin
			for (int i = 0; i < ADCRS_NCH; i++) begin
				if (store && conv_ch == adcrs_chidx_t'(i))
					done_flag[i] <= 1'b1;
				else if ((chan_hit && rd_idx == adcrs_chidx_t'(i))
					|| (rd_last && last_ch == adcrs_chidx_t'(i)))
					done_flag[i] <= 1'b0;
				if (store && conv_ch == adcrs_chidx_t'(i) && done_flag[i])
					channel_overrun_flag[i] <= 1'b1;
				else if (rd_stat)
					channel_overrun_flag[i] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// global flags: independent of channel reads and disables
	// set wins: a status read in the same cycle does not hide the overrun
	logic new_govr;
	assign new_govr = store && data_ready_flag;

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			data_ready_flag <= 1'b0;
		else if (store)
			data_ready_flag <= 1'b1;
		else if (rd_last)
			data_ready_flag <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			global_overrun_flag <= 1'b0;
		else if (new_govr)
			global_overrun_flag <= 1'b1;
		else if (rd_stat)
			global_overrun_flag <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// mode, start command and sleep deferral
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			mode_reg <= `ADCRS_MODE_RST;
		else if (wr_acc && paddr == `ADCRS_MODE_OFF)
			mode_reg <= pwdata;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			conv_start <= 1'b0;
		else
			conv_start <= wr_acc && paddr == `ADCRS_CTRL_OFF && pwdata[`ADCRS_CTRL_START];
	end

	// sleep only after a conversion ends; idle selection just arms it
	// clearing the sleep choice wakes the core from either state
	always_comb begin
		next_slp = slp;
		case (slp)
			ADCRS_AWAKE:
				if (mode_reg[`ADCRS_MODE_SLEEP])
					next_slp = ADCRS_ARMED;
			ADCRS_ARMED:
				if (!mode_reg[`ADCRS_MODE_SLEEP])
					next_slp = ADCRS_AWAKE;
				else if (conv_done)
					next_slp = ADCRS_ASLEEP;
			ADCRS_ASLEEP:
				if (!mode_reg[`ADCRS_MODE_SLEEP])
					next_slp = ADCRS_AWAKE;
			default:
				next_slp = ADCRS_AWAKE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			slp <= ADCRS_AWAKE;
		else
			slp <= next_slp;
	end
	// a start wakes the core for one conversion; sleep returns at its end
	assign sleep_now = slp == ADCRS_ASLEEP && !conv_busy && !conv_start;

	////////////////////////////////////////////////////////////////////////
	// interrupts
	logic [2:0] irq_ev;
	assign irq_ev = {store && |(done_flag & (adcrs_chmask_t'(1) << conv_ch)), new_govr, store};

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			irq_mask <= `ADCRS_MASK_RST;
		else if (wr_acc && paddr == `ADCRS_IMASK_OFF)
			irq_mask <= pwdata[2:0];
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			irq_stat <= '0;
		else if (wr_acc && paddr == `ADCRS_ISTAT_OFF)
			irq_stat <= (irq_stat & ~pwdata[2:0]) | irq_ev;
		else
			irq_stat <= irq_stat | irq_ev;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(irq_stat & irq_mask);
	end

	////////////////////////////////////////////////////////////////////////
	// read data
	// loaded in the setup cycle; read side effects land in the access phase
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			prdata <= '0;
		else if (psel && !penable && !pwrite) begin
			prdata <= '0;
			case (paddr)
				`ADCRS_MODE_OFF: prdata <= mode_reg;
				`ADCRS_CHEN_OFF: prdata <= 32'(ch_enable);
				`ADCRS_STAT_OFF: prdata <= 32'(done_flag)
					| (32'(channel_overrun_flag) << `ADCRS_STAT_OVR_LSB)
					| (32'(data_ready_flag) << `ADCRS_STAT_DATA_READY_FLAG)
					| (32'(global_overrun_flag) << `ADCRS_STAT_GOVR);
				`ADCRS_LAST_OFF: prdata <= 32'(last_res) | (32'(last_ch) << `ADCRS_LAST_CH_LSB);
				`ADCRS_IMASK_OFF: prdata <= 32'(irq_mask);
				`ADCRS_ISTAT_OFF: prdata <= 32'(irq_stat);
				default:
					if (paddr >= `ADCRS_CHRES_OFF && paddr < `ADCRS_CHRES_OFF + 12'h020)
						prdata <= 32'(chan_res[3'((paddr - `ADCRS_CHRES_OFF) >> 2)]);
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	// one-hot of the channel register being read, for the only-own-flag check
	adcrs_chmask_t chan_rd_mask;
	assign chan_rd_mask = adcrs_chmask_t'(1) << rd_idx;

	chk_data_ready_flag_chan_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		data_ready_flag && chan_hit && !rd_last |=> data_ready_flag)
		else $error("data ready lost on channel read");
	chk_data_ready_flag_only_last: assert property (@(posedge sys_clk) disable iff (!rst_n)
		data_ready_flag && !rd_last |=> data_ready_flag)
		else $error("data ready cleared without last read");
	chk_data_ready_flag_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
		store |=> data_ready_flag && last_res == $past(conv_data))
		else $error("store did not set data ready");
	chk_chan_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
		store |=> chan_res[$past(conv_ch)] == $past(conv_data))
		else $error("channel result not stored");
	chk_data_ready_flag_chan_coinc: assert property (@(posedge sys_clk) disable iff (!rst_n)
		store && chan_hit |=> data_ready_flag)
		else $error("data ready skipped");
	chk_data_ready_flag_no_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_last && !store |=> !data_ready_flag)
		else $error("data ready left set without store");
	chk_govr_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		store && data_ready_flag |=> global_overrun_flag)
		else $error("global overrun not set");
	chk_govr_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_stat && !(store && data_ready_flag) |=> !global_overrun_flag)
		else $error("global overrun not cleared");
	chk_govr_stat_coinc: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_stat && store && data_ready_flag |=> global_overrun_flag)
		else $error("overrun lost on status read");
	chk_govr_chan_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		chan_hit && store && data_ready_flag |=> global_overrun_flag)
		else $error("overrun lost on channel read");
	chk_govr_disable: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ch_disable_now && store && data_ready_flag |=> global_overrun_flag)
		else $error("global overrun lost on disable");
	chk_ovr_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		store && done_flag[conv_ch] |=> channel_overrun_flag[$past(conv_ch)])
		else $error("channel overrun not set");
	chk_ovr_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_stat && !store |=> channel_overrun_flag == '0)
		else $error("channel overrun not cleared");
	chk_ovr_stat_coinc: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_stat && store && !done_flag[conv_ch] |=> !channel_overrun_flag[$past(conv_ch)])
		else $error("channel overrun kept on status read");
	chk_done_chan_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		chan_hit && !(store && conv_ch == rd_idx) |=> !done_flag[$past(rd_idx)])
		else $error("done not cleared by channel read");
	chk_done_last_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_last && !(store && conv_ch == last_ch) |=> !done_flag[$past(last_ch)])
		else $error("done not cleared by last read");
	chk_done_only_own: assert property (@(posedge sys_clk) disable iff (!rst_n)
		chan_hit |=> ($past(done_flag) & ~$past(chan_rd_mask) & ~done_flag) == '0)
		else $error("other channel done cleared");
	chk_done_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
		conv_done && !ch_enable[conv_ch] |=> done_flag == $past(done_flag)
		|| $past(chan_hit || rd_last))
		else $error("done raised on disabled channel");
	chk_keep_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
		conv_done && !ch_enable[conv_ch] |=> last_res == $past(last_res))
		else $error("result stored for disabled channel");
	chk_done_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
		store |=> done_flag[$past(conv_ch)])
		else $error("done not set on store");
	chk_sleep_defer: assert property (@(posedge sys_clk) disable iff (!rst_n)
		slp == ADCRS_ARMED && !conv_done |=> slp != ADCRS_ASLEEP)
		else $error("sleep entered before conversion end");
	chk_sleep_enter: assert property (@(posedge sys_clk) disable iff (!rst_n)
		slp == ADCRS_ARMED && conv_done && mode_reg[`ADCRS_MODE_SLEEP]
		|=> slp == ADCRS_ASLEEP)
		else $error("sleep not entered after conversion end");
	chk_sleep_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!mode_reg[`ADCRS_MODE_SLEEP] |=> slp == ADCRS_AWAKE)
		else $error("sleep kept after choice cleared");
	chk_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
		|(irq_stat & irq_mask) |=> irq)
		else $error("interrupt not raised");

	// scenario covers
	cov_overrun: cover property (@(posedge sys_clk) disable iff (!rst_n) new_govr);
	cov_read_coinc: cover property (@(posedge sys_clk) disable iff (!rst_n) store && chan_hit);
	cov_sleep: cover property (@(posedge sys_clk) disable iff (!rst_n) slp == ADCRS_ASLEEP);
	cov_disable_coinc: cover property (@(posedge sys_clk) disable iff (!rst_n)
		store && ch_disable_now);
	cov_last_disabled: cover property (@(posedge sys_clk) disable iff (!rst_n)
		rd_last && conv_done && !ch_enable[conv_ch]);
endmodule

// >>> testbench/adc_result_status_flags_test.sv
`timescale 1ns/1ps
`include "adcrs_map.svh"
module adc_result_status_flags_test;
	import adcrs_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] q;
	logic pready, pslverr, conv_start, sleep_now, irq, err;
	logic conv_done = 1'b0;
	logic conv_busy = 1'b0;
	adcrs_chidx_t conv_ch = 3'h0;
	adcrs_result_t conv_data = 10'h000;
	adcrs_chmask_t ch_enable;
	int fail_count = 0;
	int n_tests = 0;

	always #12.5 sys_clk = ~sys_clk;

	adcrs_top adcrs_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv_done(conv_done), .conv_ch(conv_ch), .conv_data(conv_data),
		.conv_busy(conv_busy), .conv_start(conv_start), .sleep_now(sleep_now),
		.ch_enable(ch_enable), .irq(irq));

	////////////////////////////////////////////////////////////////////////////
	task print_verdict;
		if (fail_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic [31:0] st(input logic [7:0] d, input logic [7:0] o, input logic r,
		input logic g);
		return {14'h0000, g, r, o, d};
	endfunction

	// result value derived from channel so each store is traceable
	function automatic logic [31:0] last(input logic [2:0] ch);
		return {17'h0_0000, ch, 2'h0, ch, 7'h55};
	endfunction

	// optional conversion end lands on the same edge as the access phase
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic cd, input logic [2:0] ch);
		int i = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		conv_done <= cd;
		conv_ch <= ch;
		conv_data <= {ch, 7'h55};
		do begin
			@(posedge sys_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			print_verdict();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		conv_done <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
		xfer(1'b0, a, 32'h0000_0000, 1'b0, 3'h0);
		chk(nm, q, exp);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 1'b0, 3'h0);
	endtask

	task automatic conv(input logic [2:0] ch);
		@(posedge sys_clk);
		conv_busy <= 1'b1;
		conv_done <= 1'b1;
		conv_ch <= ch;
		conv_data <= {ch, 7'h55};
		@(posedge sys_clk);
		conv_busy <= 1'b0;
		conv_done <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_store;
		rd(`ADCRS_STAT_OFF, 32'h0000_0000, "stat_reset");
		rd(12'h0fc, 32'h0000_0000, "unmapped_rd");
		chk("unmapped_err", {31'h0000_0000, err}, 32'h0000_0001);
		wr(`ADCRS_CHEN_OFF, 32'h0000_00f7);
		#1 chk("enable", {24'h00_0000, ch_enable}, 32'h0000_00f7);
		conv(3'h3);
		rd(`ADCRS_STAT_OFF, 32'h0000_0000, "stat_dis_end");
		xfer(1'b0, `ADCRS_CHRES_OFF + 12'h014, 32'h0000_0000, 1'b1, 3'h0);
		rd(`ADCRS_STAT_OFF, st(8'h01, 8'h00, 1'b1, 1'b0), "stat_store");
		rd(`ADCRS_CHRES_OFF, last(3'h0) & 32'h0000_03ff, "ch0_data");
		rd(`ADCRS_STAT_OFF, st(8'h00, 8'h00, 1'b1, 1'b0), "stat_ch_rd");
		rd(`ADCRS_LAST_OFF, last(3'h0), "last_data");
		rd(`ADCRS_STAT_OFF, 32'h0000_0000, "stat_last_rd");
	endtask

	task automatic t_overrun;
		conv(3'h1);
		conv(3'h1);
		rd(`ADCRS_CHRES_OFF + 12'h004, last(3'h1) & 32'h0000_03ff, "ch1_data");
		xfer(1'b0, `ADCRS_STAT_OFF, 32'h0000_0000, 1'b1, 3'h1);
		chk("stat_ovr", q, st(8'h00, 8'h02, 1'b1, 1'b1));
		rd(`ADCRS_STAT_OFF, st(8'h02, 8'h00, 1'b1, 1'b1), "stat_rd_eoc");
		rd(`ADCRS_STAT_OFF, st(8'h02, 8'h00, 1'b1, 1'b0), "stat_govr_clr");
	endtask

	task automatic t_coincide;
		xfer(1'b0, `ADCRS_CHRES_OFF + 12'h014, 32'h0000_0000, 1'b1, 3'h1);
		rd(`ADCRS_STAT_OFF, st(8'h02, 8'h02, 1'b1, 1'b1), "stat_chrd_eoc");
		xfer(1'b1, `ADCRS_CHDIS_OFF, 32'h0000_0040, 1'b1, 3'h1);
		#1 chk("disable", {24'h00_0000, ch_enable}, 32'h0000_00b7);
		rd(`ADCRS_STAT_OFF, st(8'h02, 8'h02, 1'b1, 1'b1), "stat_dis_eoc");
		rd(`ADCRS_LAST_OFF, last(3'h1), "last_dis_eoc");
		rd(`ADCRS_STAT_OFF, 32'h0000_0000, "stat_last_ch");
		xfer(1'b1, `ADCRS_CHDIS_OFF, 32'h0000_0040, 1'b1, 3'h4);
		rd(`ADCRS_STAT_OFF, st(8'h10, 8'h00, 1'b1, 1'b0), "stat_dis_data_ready_flag");
		conv(3'h2);
		xfer(1'b0, `ADCRS_CHRES_OFF + 12'h01c, 32'h0000_0000, 1'b1, 3'h0);
		rd(`ADCRS_STAT_OFF, st(8'h15, 8'h00, 1'b1, 1'b1), "stat_other_rd");
		xfer(1'b0, `ADCRS_LAST_OFF, 32'h0000_0000, 1'b1, 3'h3);
		rd(`ADCRS_STAT_OFF, st(8'h14, 8'h00, 1'b0, 1'b0), "stat_last_dis");
	endtask

	task automatic t_irq;
		rd(`ADCRS_ISTAT_OFF, 32'h0000_0007, "istat_events");
		chk("irq_masked", {31'h0000_0000, irq}, 32'h0000_0000);
		wr(`ADCRS_IMASK_OFF, 32'h0000_0001);
		repeat (2) @(posedge sys_clk);
		#1 chk("irq_on", {31'h0000_0000, irq}, 32'h0000_0001);
		wr(`ADCRS_ISTAT_OFF, 32'h0000_0001);
		repeat (2) @(posedge sys_clk);
		#1 chk("irq_off", {31'h0000_0000, irq}, 32'h0000_0000);
		rd(`ADCRS_ISTAT_OFF, 32'h0000_0006, "istat_w1c");
	endtask

	task automatic t_sleep;
		wr(`ADCRS_MODE_OFF, 32'h0000_0020);
		repeat (3) @(posedge sys_clk);
		#1 chk("sleep_idle", {31'h0000_0000, sleep_now}, 32'h0000_0000);
		wr(`ADCRS_CTRL_OFF, 32'h0000_0002);
		#1 chk("start", {31'h0000_0000, conv_start}, 32'h0000_0001);
		conv(3'h0);
		#1 chk("sleep_after", {31'h0000_0000, sleep_now}, 32'h0000_0001);
		wr(`ADCRS_MODE_OFF, 32'h0000_0000);
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_store();
		t_overrun();
		t_coincide();
		t_irq();
		t_sleep();
		print_verdict();
	end
endmodule
